// ---- common/tsmod_regs.svh ----
`ifndef TSMOD_REGS_SVH
`define TSMOD_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets (one 32-bit word each)
// ------------------------------------------------------------
`define TSMOD_CTRL_OFS 8'h00
`define TSMOD_CMD_OFS 8'h04
`define TSMOD_START_LO_OFS 8'h08
`define TSMOD_START_HI_OFS 8'h0c
`define TSMOD_INTERVAL_LO_OFS 8'h10
`define TSMOD_INTERVAL_HI_OFS 8'h14
`define TSMOD_FIRST_LO_OFS 8'h18
`define TSMOD_FIRST_HI_OFS 8'h1c
`define TSMOD_SNAP_LO_OFS 8'h20
`define TSMOD_SNAP_HI_OFS 8'h24
`define TSMOD_STATUS_OFS 8'h28
`define TSMOD_INT_STAT_OFS 8'h2c
`define TSMOD_INT_MASK_OFS 8'h30
`define TSMOD_MASTER_ID_LO_OFS 8'h34
`define TSMOD_MASTER_ID_HI_OFS 8'h38

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define TSMOD_CTRL_ARM_BIT 0
`define TSMOD_CTRL_TRIG_EN_BIT 1
`define TSMOD_CTRL_TRIG_SRC_BIT 2
`define TSMOD_CTRL_MODE_LSB 4
`define TSMOD_CMD_CLEAR_BIT 0
`define TSMOD_CMD_SNAP_BIT 1
`define TSMOD_INT_EVENT_BIT 0
`define TSMOD_INT_FIRST_BIT 1
`define TSMOD_INT_ELECT_BIT 2
`define TSMOD_STATUS_RUN_BIT 0
`define TSMOD_STATUS_MASTER_BIT 1
`define TSMOD_STATUS_ELECT_BIT 2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TSMOD_CTRL_RESET 32'h0000_0000
`define TSMOD_INTERVAL_RESET 64'h0000_0000_0000_0000
`define TSMOD_INT_MASK_RESET 3'h0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TSMOD_CLK_PERIOD_NS 10
`define TSMOD_US_TICK_NS 1000
`define TSMOD_US_TICK_CYCLES (`TSMOD_US_TICK_NS / `TSMOD_CLK_PERIOD_NS)
`define TSMOD_SYNC_STEP_NS 8
`define TSMOD_ELECT_TIME_MS 2000
`define TSMOD_ELECT_CYCLES (`TSMOD_ELECT_TIME_MS * 1000000 / `TSMOD_CLK_PERIOD_NS)
`define TSMOD_EUI_FILL 16'hfffe

`endif

// ---- common/tsmod_pkg.sv ----
package tsmod_pkg;

   // Time base selection, in field order of the mode bits
   typedef enum logic [1:0] {
      SYNC_OFF,
      SYNC_AUTO,
      SYNC_FORCE_MASTER,
      SYNC_FORCE_SLAVE
   } sync_mode_e;

   typedef enum logic [1:0] {
      MOD_IDLE,
      MOD_DIVIDE,
      MOD_WAIT_FIRST,
      MOD_RUN
   } mod_state_e;

   typedef enum logic [1:0] {
      ELECT_IDLE,
      ELECT_LISTEN,
      ELECT_DONE
   } elect_state_e;

   typedef logic [63:0] stamp_t;
   typedef logic [47:0] mac_t;

endpackage

// ---- hw/tsmod_divider.sv ----
// ------------------------------------------------------------
// Sequential remainder, one quotient bit per clock
// ------------------------------------------------------------
module tsmod_divider #(
   parameter int WIDTH = 64
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [WIDTH-1:0] dividend,
   input wire logic [WIDTH-1:0] divisor,
   output logic done,
   output logic [WIDTH-1:0] remainder
);

   localparam int CW = $clog2(WIDTH + 1);

   logic [WIDTH-1:0] dvd_q;
   logic [WIDTH:0] rem_q;
   logic [CW-1:0] cnt_q;
   logic busy_q;
   logic [WIDTH:0] shifted;

   // Wide shift keeps the carry; rem < divisor may still double past WIDTH
   assign shifted = {rem_q[WIDTH-1:0], dvd_q[WIDTH-1]};
   assign remainder = rem_q[WIDTH-1:0];

   // Iterate WIDTH steps, one pulse of done at the end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dvd_q <= '0;
         rem_q <= '0;
         cnt_q <= '0;
         busy_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            dvd_q <= dividend;
            rem_q <= '0;
            cnt_q <= CW'(WIDTH);
            busy_q <= 1'b1;
         end else if (busy_q) begin
            dvd_q <= {dvd_q[WIDTH-2:0], 1'b0};
            if (shifted >= {1'b0, divisor}) begin
               rem_q <= shifted - {1'b0, divisor};
            end else begin
               rem_q <= shifted;
            end
            cnt_q <= cnt_q - CW'(1);
            if (cnt_q == CW'(1)) begin
               busy_q <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

endmodule // tsmod_divider

// ---- hw/timestamp_modulo_trigger.sv ----
// Functional notes
// - Internal counter advances every microsecond
// - Sync counter advances in 8 ns steps
// - Clear zeroes internal counter only; both run
// - Sync mode selects sync counter; no clear
// - Auto election, or software forces master/slave
// - Automatic election completes within two seconds
// - Lowest MAC wins the election
// - Clock identity: MAC high, fffe, MAC low
// - First event at next multiple after start
// - Events repeat every interval until disarmed
// - First event timestamp is readable
// - Near-boundary start may slip one interval
// - Clear before first event keeps target
// - Clear while running restarts at interval
// - New interval counts from previous event
// - Enabled modulo trigger starts one frame
// - Snapshot command copies current timestamp
// - Snapshot value is 64 bits wide
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`include "tsmod_regs.svh"

module timestamp_modulo_trigger #(
   parameter int ELECT_CYCLES = `TSMOD_ELECT_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [47:0] own_mac,
   input wire logic peer_mac_valid,
   input wire logic [47:0] peer_mac,
   input wire logic sync_load,
   input wire logic [63:0] sync_load_value,
   output logic modulo_event,
   output logic frame_start,
   output logic clock_is_master,
   output logic [63:0] master_clock_id,
   output logic irq
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic tsmod_pkg::stamp_t eui64(input tsmod_pkg::mac_t mac);
      eui64 = {mac[47:24], `TSMOD_EUI_FILL, mac[23:0]};
   endfunction

   function automatic logic [31:0] half(input tsmod_pkg::stamp_t v, input logic hi);
      half = hi ? v[63:32] : v[31:0];
   endfunction

   localparam int US_CYC = `TSMOD_US_TICK_CYCLES;
   localparam logic [6:0] US_LAST = 7'(US_CYC - 1);
   localparam logic [4:0] CLK_NS = 5'(`TSMOD_CLK_PERIOD_NS);
   localparam logic [4:0] STEP_NS = 5'(`TSMOD_SYNC_STEP_NS);
   localparam logic [4:0] STEP2_NS = 5'(2 * `TSMOD_SYNC_STEP_NS);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [31:0] ctrl_q;
   tsmod_pkg::stamp_t start_q;
   tsmod_pkg::stamp_t interval_q;
   tsmod_pkg::stamp_t first_q;
   tsmod_pkg::stamp_t snap_q;
   logic [2:0] int_stat_q;
   logic [2:0] int_mask_q;
   logic ap_valid_q;
   logic ap_write_q;
   logic [7:0] ap_addr_q;
   logic wr_en;
   logic clear_cmd;
   logic snap_cmd;
   logic [31:0] rd_data;
   tsmod_pkg::sync_mode_e mode;
   logic arm;

   assign mode = tsmod_pkg::sync_mode_e'(ctrl_q[`TSMOD_CTRL_MODE_LSB +: 2]);
   assign arm = ctrl_q[`TSMOD_CTRL_ARM_BIT];
   assign wr_en = ap_valid_q && ap_write_q;
   assign clear_cmd = wr_en && (ap_addr_q == `TSMOD_CMD_OFS) && hwdata[`TSMOD_CMD_CLEAR_BIT];
   assign snap_cmd = wr_en && (ap_addr_q == `TSMOD_CMD_OFS) && hwdata[`TSMOD_CMD_SNAP_BIT];

   // ------------------------------------------------------------
   // Time bases
   // ------------------------------------------------------------
   logic [6:0] us_div_q;
   tsmod_pkg::stamp_t us_cnt_q;
   tsmod_pkg::stamp_t us_cnt_d;
   logic [4:0] ns_rem_q;
   logic [4:0] ns_rem_d;
   tsmod_pkg::stamp_t ns_cnt_q;
   tsmod_pkg::stamp_t ns_cnt_d;
   tsmod_pkg::stamp_t ts_d;
   logic [4:0] ns_acc;

   // Next values of both counters; both always run
   always_comb begin
      ns_acc = ns_rem_q + CLK_NS;
      us_cnt_d = us_cnt_q;
      if (us_div_q == US_LAST) begin
         us_cnt_d = us_cnt_q + 64'h0000_0000_0000_0001;
      end
      if (clear_cmd) begin
         us_cnt_d = '0;
      end
      // A 10 ns clock covers one or two 8 ns steps; the remainder carries
      if (ns_acc >= STEP2_NS) begin
         ns_rem_d = ns_acc - STEP2_NS;
         ns_cnt_d = ns_cnt_q + 64'(STEP2_NS);
      end else begin
         ns_rem_d = ns_acc - STEP_NS;
         ns_cnt_d = ns_cnt_q + 64'(STEP_NS);
      end
      // Only the servo may move the sync counter, never a clear
      if (sync_load) begin
         ns_cnt_d = sync_load_value;
      end
      ts_d = (mode == tsmod_pkg::SYNC_OFF) ? us_cnt_d : ns_cnt_d;
   end

   // Microsecond prescaler and counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         us_div_q <= '0;
         us_cnt_q <= '0;
      end else begin
         us_div_q <= (us_div_q == US_LAST || clear_cmd) ? 7'h00 : us_div_q + 7'h01;
         us_cnt_q <= us_cnt_d;
      end
   end

   // Nanosecond counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ns_rem_q <= '0;
         ns_cnt_q <= '0;
      end else begin
         ns_rem_q <= ns_rem_d;
         ns_cnt_q <= ns_cnt_d;
      end
   end

   // Snapshot of the selected timestamp as it stands after this edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         snap_q <= '0;
      end else if (snap_cmd) begin
         snap_q <= ts_d;
      end
   end

   // ------------------------------------------------------------
   // Modulo event engine
   // ------------------------------------------------------------
   tsmod_pkg::mod_state_e mod_q;
   tsmod_pkg::stamp_t last_q;
   tsmod_pkg::stamp_t ts_q;
   tsmod_pkg::stamp_t first_calc;
   logic arm_q;
   logic div_start;
   logic div_done;
   tsmod_pkg::stamp_t div_rem;
   logic event_now;
   logic first_now;
   logic active_cleared;

   assign div_start = arm && !arm_q && (interval_q != '0);
   assign first_calc = start_q - div_rem + interval_q;
   assign active_cleared = clear_cmd && (mode == tsmod_pkg::SYNC_OFF);
   assign first_now = (mod_q == tsmod_pkg::MOD_WAIT_FIRST) && (ts_d >= first_q);
   assign event_now = first_now || ((mod_q == tsmod_pkg::MOD_RUN) && !active_cleared
                      && (ts_d >= last_q + interval_q));

   tsmod_divider #(
      .WIDTH(64)
   ) u_div (
      .clk(clk),
      .rst_n(rst_n),
      .start(div_start),
      .dividend(start_q),
      .divisor(interval_q),
      .done(div_done),
      .remainder(div_rem)
   );

   // Sequencing of the periodic events
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mod_q <= tsmod_pkg::MOD_IDLE;
         arm_q <= 1'b0;
         last_q <= '0;
         first_q <= '0;
         ts_q <= '0;
      end else begin
         arm_q <= arm;
         ts_q <= ts_d;
         case (mod_q)
            tsmod_pkg::MOD_IDLE: begin
               if (div_start) begin
                  mod_q <= tsmod_pkg::MOD_DIVIDE;
               end
            end
            tsmod_pkg::MOD_DIVIDE: begin
               if (!arm) begin
                  mod_q <= tsmod_pkg::MOD_IDLE;
               end else if (div_done) begin
                  // Boundary already passed while dividing: take the next one
                  first_q <= (first_calc <= ts_q) ? first_calc + interval_q : first_calc;
                  mod_q <= tsmod_pkg::MOD_WAIT_FIRST;
               end
            end
            tsmod_pkg::MOD_WAIT_FIRST: begin
               if (!arm) begin
                  mod_q <= tsmod_pkg::MOD_IDLE;
               end else if (first_now) begin
                  first_q <= ts_d;
                  last_q <= ts_d;
                  mod_q <= tsmod_pkg::MOD_RUN;
               end
            end
            tsmod_pkg::MOD_RUN: begin
               if (!arm) begin
                  mod_q <= tsmod_pkg::MOD_IDLE;
               end else if (active_cleared) begin
                  last_q <= '0;
               end else if (event_now) begin
                  last_q <= ts_d;
               end
            end
            default: begin
               mod_q <= tsmod_pkg::MOD_IDLE;
            end
         endcase
      end
   end

   // Event pulse lands with the counter value that caused it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         modulo_event <= 1'b0;
         frame_start <= 1'b0;
      end else begin
         modulo_event <= event_now;
         frame_start <= event_now && ctrl_q[`TSMOD_CTRL_TRIG_EN_BIT]
                        && ctrl_q[`TSMOD_CTRL_TRIG_SRC_BIT];
      end
   end

   // ------------------------------------------------------------
   // Clock master election
   // ------------------------------------------------------------
   tsmod_pkg::elect_state_e elect_q;
   logic [31:0] elect_cnt_q;
   tsmod_pkg::mac_t best_q;
   logic elect_done_evt;

   assign elect_done_evt = (elect_q == tsmod_pkg::ELECT_LISTEN) && (elect_cnt_q == 32'(ELECT_CYCLES - 1));

   // Listen for peer candidates during a bounded window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         elect_q <= tsmod_pkg::ELECT_IDLE;
         elect_cnt_q <= '0;
         best_q <= '0;
      end else begin
         case (elect_q)
            tsmod_pkg::ELECT_IDLE: begin
               elect_cnt_q <= '0;
               best_q <= own_mac;
               if (mode == tsmod_pkg::SYNC_AUTO) begin
                  elect_q <= tsmod_pkg::ELECT_LISTEN;
               end
            end
            tsmod_pkg::ELECT_LISTEN: begin
               elect_cnt_q <= elect_cnt_q + 32'h0000_0001;
               if (peer_mac_valid && peer_mac < best_q) begin
                  best_q <= peer_mac;
               end
               if (mode != tsmod_pkg::SYNC_AUTO) begin
                  elect_q <= tsmod_pkg::ELECT_IDLE;
               end else if (elect_done_evt) begin
                  elect_q <= tsmod_pkg::ELECT_DONE;
               end
            end
            tsmod_pkg::ELECT_DONE: begin
               // A better candidate arriving later still takes over
               if (peer_mac_valid && peer_mac < best_q) begin
                  best_q <= peer_mac;
               end
               if (mode != tsmod_pkg::SYNC_AUTO) begin
                  elect_q <= tsmod_pkg::ELECT_IDLE;
               end
            end
            default: begin
               elect_q <= tsmod_pkg::ELECT_IDLE;
            end
         endcase
      end
   end

   // Role and identity, forced by software or taken from the election
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_is_master <= 1'b0;
         master_clock_id <= '0;
      end else begin
         case (mode)
            tsmod_pkg::SYNC_FORCE_MASTER: begin
               clock_is_master <= 1'b1;
               master_clock_id <= eui64(own_mac);
            end
            tsmod_pkg::SYNC_FORCE_SLAVE: begin
               clock_is_master <= 1'b0;
               master_clock_id <= eui64(best_q);
            end
            tsmod_pkg::SYNC_AUTO: begin
               if (elect_q == tsmod_pkg::ELECT_DONE) begin
                  clock_is_master <= (best_q == own_mac);
                  master_clock_id <= eui64(best_q);
               end
            end
            default: begin
               clock_is_master <= 1'b0;
               master_clock_id <= '0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // AHB-Lite slave: one wait state on every transfer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_addr_q <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= '0;
      end else begin
         hresp <= 1'b0;
         if (ap_valid_q) begin
            ap_valid_q <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= ap_write_q ? 32'h0000_0000 : rd_data;
         end else if (hsel && hready && htrans[1]) begin
            // hsize is not checked: only whole words are supported
            ap_valid_q <= 1'b1;
            ap_write_q <= hwrite;
            ap_addr_q <= {haddr[7:2], 2'b00};
            hreadyout <= 1'b0;
         end
      end
   end

   // Software-written registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `TSMOD_CTRL_RESET;
         start_q <= '0;
         interval_q <= `TSMOD_INTERVAL_RESET;
         int_mask_q <= `TSMOD_INT_MASK_RESET;
      end else if (wr_en) begin
         case (ap_addr_q)
            `TSMOD_CTRL_OFS: ctrl_q <= hwdata & 32'h0000_0037;
            `TSMOD_START_LO_OFS: start_q[31:0] <= hwdata;
            `TSMOD_START_HI_OFS: start_q[63:32] <= hwdata;
            `TSMOD_INTERVAL_LO_OFS: interval_q[31:0] <= hwdata;
            `TSMOD_INTERVAL_HI_OFS: interval_q[63:32] <= hwdata;
            `TSMOD_INT_MASK_OFS: int_mask_q <= hwdata[2:0];
            default: begin
            end
         endcase
      end
   end

   // Sticky status; a new event beats a same-cycle write-one clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_stat_q <= '0;
         irq <= 1'b0;
      end else begin
         int_stat_q <= (int_stat_q & ~((wr_en && ap_addr_q == `TSMOD_INT_STAT_OFS) ? hwdata[2:0] : 3'h0))
                       | {elect_done_evt, first_now, event_now};
         irq <= |(int_stat_q & int_mask_q);
      end
   end

   // Read multiplexer
   always_comb begin
      rd_data = 32'h0000_0000;
      case (ap_addr_q)
         `TSMOD_CTRL_OFS: rd_data = ctrl_q;
         `TSMOD_START_LO_OFS: rd_data = half(start_q, 1'b0);
         `TSMOD_START_HI_OFS: rd_data = half(start_q, 1'b1);
         `TSMOD_INTERVAL_LO_OFS: rd_data = half(interval_q, 1'b0);
         `TSMOD_INTERVAL_HI_OFS: rd_data = half(interval_q, 1'b1);
         `TSMOD_FIRST_LO_OFS: rd_data = half(first_q, 1'b0);
         `TSMOD_FIRST_HI_OFS: rd_data = half(first_q, 1'b1);
         `TSMOD_SNAP_LO_OFS: rd_data = half(snap_q, 1'b0);
         `TSMOD_SNAP_HI_OFS: rd_data = half(snap_q, 1'b1);
         `TSMOD_STATUS_OFS: rd_data = {29'h0000_0000, elect_q == tsmod_pkg::ELECT_DONE,
                                       clock_is_master, mod_q == tsmod_pkg::MOD_RUN};
         `TSMOD_INT_STAT_OFS: rd_data = {29'h0000_0000, int_stat_q};
         `TSMOD_INT_MASK_OFS: rd_data = {29'h0000_0000, int_mask_q};
         `TSMOD_MASTER_ID_LO_OFS: rd_data = half(master_clock_id, 1'b0);
         `TSMOD_MASTER_ID_HI_OFS: rd_data = half(master_clock_id, 1'b1);
         default: rd_data = 32'h0000_0000;
      endcase
   end

endmodule // timestamp_modulo_trigger

// ---- verif/tsmod_monitor.sv ----
module tsmod_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic hready,
   input wire logic [1:0] htrans,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [47:0] own_mac,
   input wire logic modulo_event,
   input wire logic frame_start,
   input wire logic clock_is_master,
   input wire logic [63:0] master_clock_id
);
   timeunit 1ns / 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // -------------------------------------------------
   // Bus and event relations
   // -------------------------------------------------
   sequence s_take;
      hsel && hready && htrans[1] && hreadyout;
   endsequence
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_take;
      s_take |=> s_wait;
   endproperty
   a_take: assert property (p_take) else $error("no single wait state");
   property p_idle;
      !(hsel && hready && htrans[1]) && hreadyout |=> hreadyout;
   endproperty
   a_idle: assert property (p_idle) else $error("wait state without transfer");
   property p_rdy;
      !hreadyout |=> hreadyout;
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready low too long");
   property p_data;
      $changed(hrdata) |-> $rose(hreadyout);
   endproperty
   a_data: assert property (p_data) else $error("read data moved off completion");
   property p_resp;
      hresp == 1'b0;
   endproperty
   a_resp: assert property (p_resp) else $error("response not okay");
   // Mode-off events lie a whole tick apart, so eight quiet cycles are safe
   property p_pulse;
      modulo_event |=> !modulo_event [*8];
   endproperty
   a_pulse: assert property (p_pulse) else $error("event not a lone pulse");
   property p_frame;
      frame_start |-> modulo_event;
   endproperty
   a_frame: assert property (p_frame) else $error("frame without event");
   property p_id;
      clock_is_master && $past(clock_is_master) |-> master_clock_id == {own_mac[47:24], 16'hfffe, own_mac[23:0]};
   endproperty
   a_id: assert property (p_id) else $error("master identity wrong");
endmodule // tsmod_monitor

bind timestamp_modulo_trigger tsmod_monitor tsmod_monitor_inst (.clk, .rst_n, .hsel, .hready, .htrans, .hreadyout,
   .hresp, .hrdata, .own_mac, .modulo_event, .frame_start, .clock_is_master, .master_clock_id);

// ---- verif/tsmod_partner.sv ----
module tsmod_partner (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic frame_start,
   input wire logic peer_go,
   input wire logic load_go,
   output logic peer_mac_valid,
   output logic [47:0] peer_mac,
   output logic sync_load,
   output logic [63:0] sync_load_value,
   output int frames
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      peer_mac_valid = 1'b0;
      peer_mac = 48'h0000_0000_0000;
      sync_load = 1'b0;
      sync_load_value = 64'h0000_0000_0000_0000;
   end
   // Count frames started by the trigger
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) frames <= 0;
      else if (frame_start) frames <= frames + 1;
   end
   // Values outside a pulse flip every cycle, so nothing stale looks valid
   always @(posedge clk) begin
      peer_mac_valid <= peer_go;
      peer_mac <= peer_go ? 48'h0a1b_2c3d_4e00 : ~peer_mac;
      sync_load <= load_go;
      sync_load_value <= load_go ? 64'h0000_0001_0000_0000 : ~sync_load_value;
   end
endmodule // tsmod_partner

// ---- verif/timestamp_modulo_trigger_test.sv ----
`include "tsmod_regs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module timestamp_modulo_trigger_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, peer_go = 1'b0, load_go = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [7:0] haddr = 8'h00;
   logic [31:0] hwdata = 32'h0000_0000, hrdata, rd, a, b;
   logic [47:0] own_mac = 48'h0a1b_2c3d_4e5f, peer_mac;
   logic [63:0] sync_load_value, master_clock_id;
   logic hreadyout, hresp, modulo_event, frame_start, clock_is_master, irq, peer_mac_valid, sync_load;
   int n_errors = 0, num_checks = 0, cyc = 0, t0, t1, te, frames;

   timestamp_modulo_trigger #(.ELECT_CYCLES(50)) timestamp_modulo_trigger_inst (.clk, .rst_n, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .own_mac,
      .peer_mac_valid, .peer_mac, .sync_load, .sync_load_value, .modulo_event, .frame_start, .clock_is_master,
      .master_clock_id, .irq);
   tsmod_partner tsmod_partner_inst (.clk, .rst_n, .frame_start, .peer_go, .load_go, .peer_mac_valid, .peer_mac,
      .sync_load, .sync_load_value, .frames);

   // -------------------------------------------------
   // Clock, cycle count and bus tasks
   // -------------------------------------------------
   initial forever #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // Address phase, then data phase, each held until ready
   task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] d);
      hsel <= 1'b1; haddr <= ad; htrans <= 2'b10; hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      xfer(ad, 1'b1, d);
   endtask
   task automatic rdk(input string n, input logic [7:0] ad, input logic [31:0] e);
      xfer(ad, 1'b0, 32'h0000_0000);
      `CHK(n, e, rd)
   endtask
   // Always step one edge first, so one pulse is never counted twice
   task automatic wait_ev();
      int k;
      k = 0;
      do @(posedge clk); while (modulo_event !== 1'b1 && ++k < 30000);
      t1 = cyc;
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      finish_test();
   end
   // -------------------------------------------------
   // Test sequence
   // -------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdk("ctrl", `TSMOD_CTRL_OFS, 32'h0000_0000);
      rdk("mask", `TSMOD_INT_MASK_OFS, 32'h0000_0000);
      rdk("intv", `TSMOD_INTERVAL_LO_OFS, 32'h0000_0000);
      rdk("unmapped", 8'h3c, 32'h0000_0000);
      // Start 20, interval 10, frame trigger on
      wr(`TSMOD_CMD_OFS, 32'h0000_0001);
      t0 = cyc;
      wr(`TSMOD_START_LO_OFS, 32'h0000_0014);
      wr(`TSMOD_INTERVAL_LO_OFS, 32'h0000_000a);
      wr(`TSMOD_CTRL_OFS, 32'h0000_0007);
      wait_ev();
      te = t1;
      `CHK("t_first", 1'b1, (te - t0) inside {[2990:3010]})
      wait_ev();
      `CHK("gap10", 1000, t1 - te)
      rdk("first", `TSMOD_FIRST_LO_OFS, 32'h0000_001e);
      te = t1;
      wr(`TSMOD_INTERVAL_LO_OFS, 32'h0000_0014);
      wait_ev();
      `CHK("gap20", 2000, t1 - te)
      repeat (500) @(posedge clk);
      wr(`TSMOD_CMD_OFS, 32'h0000_0001);
      t0 = cyc;
      wait_ev();
      `CHK("t_clr_run", 1'b1, (t1 - t0) inside {[1990:2010]})
      repeat (2) @(posedge clk);
      `CHK("frames", 4, frames)
      // Disarmed, trigger on: no frames
      wr(`TSMOD_CTRL_OFS, 32'h0000_0006);
      repeat (2500) @(posedge clk);
      `CHK("stopped", 4, frames)
      // Interval back to 10; clear at 25 before first event
      wr(`TSMOD_INTERVAL_LO_OFS, 32'h0000_000a);
      wr(`TSMOD_CMD_OFS, 32'h0000_0001);
      t0 = cyc;
      wr(`TSMOD_CTRL_OFS, 32'h0000_0001);
      while (cyc - t0 < 2500) @(posedge clk);
      wr(`TSMOD_CMD_OFS, 32'h0000_0001);
      t0 = cyc;
      wait_ev();
      `CHK("t_clr_wait", 1'b1, (t1 - t0) inside {[2990:3010]})
      rdk("first_kept", `TSMOD_FIRST_LO_OFS, 32'h0000_001e);
      `CHK("no_trig", 4, frames)
      // Interrupt masked, unmasked, cleared
      wr(`TSMOD_CTRL_OFS, 32'h0000_0000);
      repeat (3) @(posedge clk);
      `CHK("irq_masked", 1'b0, irq)
      wr(`TSMOD_INT_MASK_OFS, 32'h0000_0001);
      repeat (3) @(posedge clk);
      `CHK("irq_on", 1'b1, irq)
      wr(`TSMOD_INT_STAT_OFS, 32'h0000_0007);
      repeat (3) @(posedge clk);
      `CHK("irq_off", 1'b0, irq)
      rdk("int_stat", `TSMOD_INT_STAT_OFS, 32'h0000_0000);
      // Forced master on the nanosecond base
      wr(`TSMOD_CTRL_OFS, 32'h0000_0020);
      repeat (3) @(posedge clk);
      `CHK("master", 1'b1, clock_is_master)
      `CHK("id", {own_mac[47:24], 16'hfffe, own_mac[23:0]}, master_clock_id)
      rdk("id_lo", `TSMOD_MASTER_ID_LO_OFS, {8'hfe, own_mac[23:0]});
      wr(`TSMOD_CMD_OFS, 32'h0000_0002);
      xfer(`TSMOD_SNAP_LO_OFS, 1'b0, 32'h0000_0000);
      a = rd;
      repeat (100) @(posedge clk);
      wr(`TSMOD_CMD_OFS, 32'h0000_0003);
      wr(`TSMOD_CMD_OFS, 32'h0000_0002);
      xfer(`TSMOD_SNAP_LO_OFS, 1'b0, 32'h0000_0000);
      b = rd;
      `CHK("ns_rate", 1'b1, (b - a) inside {[1000:1300]})
      `CHK("ns_step", 3'h0, b[2:0])
      `CHK("no_clear", 1'b1, b > a)
      load_go <= 1'b1;
      @(posedge clk);
      load_go <= 1'b0;
      repeat (3) @(posedge clk);
      wr(`TSMOD_CMD_OFS, 32'h0000_0002);
      rdk("snap_hi", `TSMOD_SNAP_HI_OFS, 32'h0000_0001);
      // Automatic election against a lower peer address
      wr(`TSMOD_CTRL_OFS, 32'h0000_0010);
      peer_go <= 1'b1;
      @(posedge clk);
      peer_go <= 1'b0;
      repeat (100) @(posedge clk);
      rdk("elected", `TSMOD_STATUS_OFS, 32'h0000_0004);
      `CHK("slave", 1'b0, clock_is_master)
      `CHK("peer_id", 64'h0a1b_2cff_fe3d_4e00, master_clock_id)
      finish_test();
   end
endmodule // timestamp_modulo_trigger_test
